// File: rtl/bstp_chain.sv
`timescale 1ns/1ps
`default_nettype none
module bstp_chain (
  // clock and reset
  input  wire logic                            mclk_in,
  input  wire logic                            sys_rst_in,
  // scan control from the controller
  input  wire logic                            cap_in,
  input  wire logic                            shift_in,
  input  wire logic                            upd_in,
  input  wire logic                            tdi_in,
  input  wire logic                            extest_in,
  input  wire logic                            hiz_in,
  // pins and core
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    pin_in,
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    core_out_in,
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    core_oe_in,
  // results
  output logic                                 so_out,
  output logic [bstp_pkg::BSR_LEN-1:0]         pin_out,
  output logic [bstp_pkg::BSR_LEN-1:0]         pin_oe_out,
  output logic                                 pin_pu_out
);
  import bstp_pkg::*;

  typedef struct packed {
    logic [BSR_LEN-1:0] pin_s1;
    logic [BSR_LEN-1:0] pin_s2;
    logic [BSR_LEN-1:0] sh;
    logic [BSR_LEN-1:0] upd;
    logic [BSR_LEN-1:0] pout;
    logic [BSR_LEN-1:0] poe;
    logic               pu;
  } bstp_chain_st_t;

  bstp_chain_st_t r;
  bstp_chain_st_t n;

  ////////////////////////////////////////////////////////////////////////////
  // capture pins, shift toward the lsb, update the output latches
  always_comb begin
    n = r;
    n.pin_s1 = pin_in;
    n.pin_s2 = r.pin_s1;
    if (cap_in) begin
      n.sh = r.pin_s2;                                  // [R2] [R3]
    end else if (shift_in) begin
      n.sh = {tdi_in, r.sh[BSR_LEN-1:1]};
    end
    if (upd_in) begin
      n.upd = r.sh;                                     // [R2]
    end
    // isp wins over everything so the board never sees a half-driven pin
    n.pu = hiz_in;                                      // [R14]
    if (hiz_in) begin
      n.pout = '0;
      n.poe  = '0;                                      // [R14]
    end else if (extest_in) begin
      n.pout = r.upd;                                   // [R3]
      n.poe  = '1;
    end else begin
      n.pout = core_out_in;
      n.poe  = core_oe_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign so_out     = r.sh[0];
  assign pin_out    = r.pout;
  assign pin_oe_out = r.poe;
  assign pin_pu_out = r.pu;

  AST_EXTEST_DRIVE: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R3]
    (extest_in && !hiz_in) |=> (pin_out == $past(r.upd)) && (&pin_oe_out))
    else $error("extest pattern not driven on pins");

endmodule
`default_nettype wire

// File: rtl/bstp_pkg.sv
package bstp_pkg;

  // widths and lengths of the scan paths
  localparam int IR_W    = 10;
  localparam int ID_W    = 32;
  localparam int BSR_LEN = 288;
  localparam int CFG_W   = 32;

  // instruction codes
  localparam logic [IR_W-1:0] IR_EXTEST     = 10'h000;
  localparam logic [IR_W-1:0] IR_SAMPLE     = 10'h055;
  localparam logic [IR_W-1:0] IR_IDCODE     = 10'h059;
  localparam logic [IR_W-1:0] IR_ISP_ERASE  = 10'h200;
  localparam logic [IR_W-1:0] IR_ISP_PROG   = 10'h201;
  localparam logic [IR_W-1:0] IR_ISP_READ   = 10'h202;
  localparam logic [IR_W-1:0] IR_ISP_SECURE = 10'h203;
  localparam logic [IR_W-1:0] IR_BYPASS     = 10'h3ff;
  localparam logic [IR_W-1:0] IR_CAPTURE    = 10'h001;

  // identification fields, values arbitrary
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h5a5a;
  localparam logic [10:0] ID_MAKER   = 11'h2a5;
  localparam logic        ID_FIXED   = 1'h1;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED};

  // erased nonvolatile contents
  localparam logic [CFG_W-1:0] CFG_ERASED = 32'hffff_ffff;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0, ST_IDLE    = 4'h1, ST_SEL_DR  = 4'h2, ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4, ST_EX1_DR  = 4'h5, ST_PAU_DR  = 4'h6, ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8, ST_SEL_IR  = 4'h9, ST_CAP_IR  = 4'ha, ST_SH_IR   = 4'hb,
    ST_EX1_IR  = 4'hc, ST_PAU_IR  = 4'hd, ST_EX2_IR  = 4'he, ST_UPD_IR  = 4'hf
  } bstp_state_t;

  typedef enum logic [1:0] {
    DR_BYP = 2'h0, DR_ID = 2'h1, DR_BSR = 2'h2, DR_CFG = 2'h3
  } bstp_dr_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstp_tap_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bstp_tap_out_t;

endpackage

// File: rtl/bstp_port.sv
// Behaviour
// (R1) The instruction register is 10 bits and shifts from TDI to TDO.
// (R2) Sample/preload captures pin levels without disturbing the core and preloads a pattern.
// (R3) External test drives the updated pattern on pins and captures the pin inputs.
// (R4) Bypass puts one stage between TDI and TDO, shifting in step with TCK.
// (R5) The identification instruction shifts the identification register out on TDO.
// (R6) The boundary-scan chain length is fixed per variant, 288 here.
// (R7) Without boundary-scan support, external test and sample/preload select bypass.
// (R8) The identification word is version, part number, maker and a final fixed bit.
// (R9) The identification lsb is one and leaves TDO first.
// (R10) With the test port disabled the four port pins are released to the user.
// (R11) Programming instructions write the nonvolatile contents serially.
// (R12) With the security bit set no readout of programmed contents is given.
// (R13) Security bit and contents stay until a full erase, which alone clears security; sys_rst_in here also clears security and erases contents.
// (R14) During programming all user pins float with a weak pull-up.
// (R15) A sixteen-state controller runs on TCK, TDO moves on the falling edge, off outside shift.
`timescale 1ns/1ps
`default_nettype none
module bstp_port #(
  parameter bit BST_ON = 1'b1
) (
  // clock and reset
  input  wire logic                            mclk_in,
  input  wire logic                            sys_rst_in,
  // test port pins and enable from configuration
  input  wire bstp_pkg::bstp_tap_in_t          tap_in,
  input  wire logic                            tap_en_in,
  // user pins and core
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    pin_in,
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    core_out_in,
  input  wire logic [bstp_pkg::BSR_LEN-1:0]    core_oe_in,
  // outputs
  output bstp_pkg::bstp_tap_out_t              tap_out,
  output logic                                 tap_released_out,
  output logic                                 secure_out,
  output logic [bstp_pkg::BSR_LEN-1:0]         pin_out,
  output logic [bstp_pkg::BSR_LEN-1:0]         pin_oe_out,
  output logic                                 pin_pu_out
);
  import bstp_pkg::*;

  typedef struct packed {
    logic             tck_s1, tck_s2, tck_s3;
    logic             tms_s1, tms_s2;
    logic             tdi_s1, tdi_s2;
    logic             en_s1, en_s2;
    bstp_state_t      st;
    logic [IR_W-1:0]  ir_sh;
    logic [IR_W-1:0]  ir;
    logic             byp;
    logic [ID_W-1:0]  id_sh;
    logic [CFG_W-1:0] cfg_sh;
    logic [CFG_W-1:0] cfg;
    logic             secure;
    logic             tdo;
    logic             tdo_oe;
    logic             released;
  } bstp_port_st_t;

  bstp_port_st_t r;
  bstp_port_st_t n;
  logic          rise;
  logic          fall;
  bstp_dr_t      sel;
  logic          isp;
  logic          extest;
  logic          chain_so;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic bstp_dr_t dr_of(input logic [IR_W-1:0] ir);
    unique case (ir)
      IR_IDCODE:                           dr_of = DR_ID;     // [R5]
      IR_EXTEST, IR_SAMPLE:                dr_of = BST_ON ? DR_BSR : DR_BYP; // [R7]
      IR_ISP_PROG, IR_ISP_READ:            dr_of = DR_CFG;
      default:                             dr_of = DR_BYP;    // [R4]
    endcase
  endfunction

  function automatic logic is_isp(input logic [IR_W-1:0] ir);
    is_isp = (ir == IR_ISP_ERASE) || (ir == IR_ISP_PROG) ||
             (ir == IR_ISP_READ) || (ir == IR_ISP_SECURE);
  endfunction

  function automatic bstp_state_t step(input bstp_state_t s, input logic tms);
    unique case (s)
      ST_RESET:  step = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   step = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: step = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: step = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  step = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: step = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: step = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: step = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: step = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: step = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: step = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  step = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: step = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: step = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: step = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: step = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // tck edges are found from the second and third sync stages only
  assign rise   = r.tck_s2 && !r.tck_s3;
  assign fall   = !r.tck_s2 && r.tck_s3;
  assign sel    = dr_of(r.ir);
  assign isp    = is_isp(r.ir);
  assign extest = BST_ON && (r.ir == IR_EXTEST);

  ////////////////////////////////////////////////////////////////////////////
  // controller, instruction path and data paths
  always_comb begin
    n = r;
    n.tck_s1 = tap_in.tck;
    n.tck_s2 = r.tck_s1;
    n.tck_s3 = r.tck_s2;
    n.tms_s1 = tap_in.tms;
    n.tms_s2 = r.tms_s1;
    n.tdi_s1 = tap_in.tdi;
    n.tdi_s2 = r.tdi_s1;
    n.en_s1  = tap_en_in;
    n.en_s2  = r.en_s1;
    if (!r.en_s2) begin
      // port pins belong to the user; the controller sits in reset
      n.st       = ST_RESET;                                  // [R10]
      n.ir       = IR_IDCODE;
      n.tdo_oe   = 1'b0;
      n.released = 1'b1;
    end else begin
      n.released = 1'b0;
      if (rise) begin
        n.st = step(r.st, r.tms_s2);                          // [R15]
        unique case (r.st)
          ST_RESET:  n.ir = IR_IDCODE;
          ST_CAP_IR: n.ir_sh = IR_CAPTURE;
          ST_SH_IR:  n.ir_sh = {r.tdi_s2, r.ir_sh[IR_W-1:1]}; // [R1]
          ST_UPD_IR: begin
            n.ir = r.ir_sh;                                   // [R1]
            // erase is the only instruction that clears security
            if (r.ir_sh == IR_ISP_ERASE) begin
              n.cfg    = CFG_ERASED;                          // [R11] [R13]
              n.secure = 1'b0;                                // [R13]
            end else if (r.ir_sh == IR_ISP_SECURE) begin
              n.secure = 1'b1;
            end
          end
          ST_CAP_DR: begin
            n.byp   = 1'b0;
            n.id_sh = ID_VALUE;                               // [R5] [R8] [R9]
            n.cfg_sh = (r.secure || r.ir != IR_ISP_READ) ? '0 : r.cfg; // [R12]
          end
          ST_SH_DR: begin
            n.byp    = r.tdi_s2;                              // [R4]
            n.id_sh  = {r.tdi_s2, r.id_sh[ID_W-1:1]};         // [R5]
            n.cfg_sh = {r.tdi_s2, r.cfg_sh[CFG_W-1:1]};       // [R11]
          end
          ST_UPD_DR: begin
            // a secured part must be erased before it takes new contents
            if (r.ir == IR_ISP_PROG && !r.secure) begin
              n.cfg = r.cfg_sh;                               // [R11] [R13]
            end
          end
          default: ;
        endcase
      end
      if (fall) begin
        n.tdo_oe = (r.st == ST_SH_DR) || (r.st == ST_SH_IR);  // [R15]
        if (r.st == ST_SH_IR) begin
          n.tdo = r.ir_sh[0];
        end else begin
          unique case (sel)
            DR_ID:   n.tdo = r.id_sh[0];                      // [R9]
            DR_BSR:  n.tdo = chain_so;
            DR_CFG:  n.tdo = r.cfg_sh[0];
            DR_BYP:  n.tdo = r.byp;                           // [R4]
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      r        <= '0;
      // enable sync starts as in use, so no false release pulse follows reset
      r.en_s1  <= 1'b1;
      r.en_s2  <= 1'b1;
      r.st     <= ST_RESET;
      r.ir     <= IR_IDCODE;
      r.cfg    <= CFG_ERASED;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boundary-scan cells and user pin drivers
  bstp_chain u_chain (
    .mclk_in     (mclk_in),
    .sys_rst_in  (sys_rst_in),
    .cap_in      (rise && r.en_s2 && r.st == ST_CAP_DR && sel == DR_BSR), // [R6]
    .shift_in    (rise && r.en_s2 && r.st == ST_SH_DR && sel == DR_BSR),
    .upd_in      (rise && r.en_s2 && r.st == ST_UPD_DR && sel == DR_BSR),
    .tdi_in      (r.tdi_s2),
    .extest_in   (extest),
    .hiz_in      (isp),                                       // [R14]
    .pin_in      (pin_in),
    .core_out_in (core_out_in),
    .core_oe_in  (core_oe_in),
    .so_out      (chain_so),
    .pin_out     (pin_out),
    .pin_oe_out  (pin_oe_out),
    .pin_pu_out  (pin_pu_out)
  );

  assign tap_out.tdo      = r.tdo;
  assign tap_out.tdo_oe   = r.tdo_oe;
  assign tap_released_out = r.released;
  assign secure_out       = r.secure;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  AST_IR_LOAD: assert property ( // [R1]
    (r.en_s2 && rise && r.st == ST_UPD_IR) |=> (r.ir == $past(r.ir_sh)))
    else $error("instruction not loaded on update");
  AST_BYPASS_STAGE: assert property ( // [R4]
    (r.en_s2 && rise && r.st == ST_SH_DR && sel == DR_BYP) |=> (r.byp == $past(r.tdi_s2)))
    else $error("bypass stage did not take tdi");
  AST_ID_CAPTURE: assert property ( // [R9]
    (r.en_s2 && rise && r.st == ST_CAP_DR) |=> (r.id_sh == ID_VALUE) && r.id_sh[0])
    else $error("identification word not captured");
  AST_SECURE_READ: assert property ( // [R12]
    (r.en_s2 && rise && r.st == ST_CAP_DR && r.secure) |=> (r.cfg_sh == '0))
    else $error("secured contents were read out");
  AST_SECURE_HOLD: assert property ( // [R13]
    (r.secure && !(r.en_s2 && rise && r.st == ST_UPD_IR && r.ir_sh == IR_ISP_ERASE))
      |=> r.secure && ($stable(r.cfg)))
    else $error("security or contents changed without erase");
  AST_ISP_FLOAT: assert property ( // [R14]
    isp |=> (pin_oe_out == '0) && pin_pu_out)
    else $error("user pins driven during programming");
  AST_TDO_OFF: assert property ( // [R15]
    (r.en_s2 && fall && r.st != ST_SH_DR && r.st != ST_SH_IR) |=> !tap_out.tdo_oe)
    else $error("tdo enabled outside shift");
  AST_RELEASE: assert property ( // [R10]
    !r.en_s2 |=> tap_released_out && !tap_out.tdo_oe && (r.st == ST_RESET))
    else $error("port not released when disabled");
  AST_SMALL_BYP: assert property ( // [R7]
    (!BST_ON && r.ir == IR_EXTEST) |-> (sel == DR_BYP))
    else $error("small variant did not select bypass");

endmodule
`default_nettype wire

// File: verification/bstp_tap_model.sv
`timescale 1ns/1ps
`default_nettype none
module bstp_tap_model (
  // clock
  input  wire logic                    mclk_in,
  // test port as the controller sees it
  input  wire bstp_pkg::bstp_tap_out_t dev_in,
  output bstp_pkg::bstp_tap_in_t       drv_out,
  output logic                         oe_shift_out,
  output logic                         oe_idle_out
);
  import bstp_pkg::*;
  logic oe_last;
  // test clock stands still between frames
  initial begin
    drv_out = '0;
    oe_shift_out = 1'b0;
    oe_idle_out = 1'b0;
    oe_last = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one 200 ns test clock; tdo is read late in the high phase, since it
  // only moves a few mclk after a fall and stands until the next one
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge mclk_in);
    drv_out.tck = 1'b0;
    drv_out.tms = tms;
    drv_out.tdi = tdi;
    repeat (4) @(negedge mclk_in);
    drv_out.tck = 1'b1;
    repeat (3) @(negedge mclk_in);
    // an undriven tdo line floats up to its pull-up
    tdo = dev_in.tdo_oe ? dev_in.tdo : 1'b1;
    oe_last = dev_in.tdo_oe;
  endtask
  // five high tms bits reach reset from any state, then idle
  task automatic tap_reset();
    logic d;
    repeat (5) step(1'b1, ~drv_out.tdi, d);
    step(1'b0, ~drv_out.tdi, d);
  endtask
  // idle to shift, n bits lsb first, update, idle; tdi toggles outside shift
  task automatic scan(input logic is_ir, input int n, input logic [319:0] din,
                      output logic [319:0] dout);
    logic d;
    dout = '0;
    oe_shift_out = 1'b1;
    step(1'b1, ~drv_out.tdi, d);
    if (is_ir) step(1'b1, ~drv_out.tdi, d);
    repeat (2) step(1'b0, ~drv_out.tdi, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
      oe_shift_out = oe_shift_out & oe_last;
    end
    step(1'b1, ~drv_out.tdi, d);
    step(1'b0, ~drv_out.tdi, d);
    oe_idle_out = oe_last;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// case-equality compare that counts and reports
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import bstp_pkg::*;
  logic               mclk, rst, tap_en;
  logic [BSR_LEN-1:0] pins, core_o, core_oe, pin_o, pin_oe, sm_po, sm_poe;
  bstp_tap_in_t       tap_drv;
  bstp_tap_out_t      tap_res;
  logic               released, secure, pull_up, oe_shift, oe_idle;
  logic [319:0]       rd;
  int                 failures, checked;
  // device and far-side controller
  bstp_port #(.BST_ON(1'b1)) dut_u (
    .mclk_in(mclk), .sys_rst_in(rst), .tap_in(tap_drv), .tap_en_in(tap_en),
    .pin_in(pins), .core_out_in(core_o), .core_oe_in(core_oe), .tap_out(tap_res),
    .tap_released_out(released), .secure_out(secure), .pin_out(pin_o),
    .pin_oe_out(pin_oe), .pin_pu_out(pull_up)
  );
  // small variant on the same port pins; only its pin drivers are watched
  bstp_port #(.BST_ON(1'b0)) dut_small_u (
    .mclk_in(mclk), .sys_rst_in(rst), .tap_in(tap_drv), .tap_en_in(tap_en),
    .pin_in(pins), .core_out_in(core_o), .core_oe_in(core_oe), .tap_out(),
    .tap_released_out(), .secure_out(), .pin_out(sm_po),
    .pin_oe_out(sm_poe), .pin_pu_out()
  );
  bstp_tap_model tap_u (
    .mclk_in(mclk), .dev_in(tap_res), .drv_out(tap_drv),
    .oe_shift_out(oe_shift), .oe_idle_out(oe_idle)
  );
  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ir(input logic [IR_W-1:0] code);
    tap_u.scan(1'b1, IR_W, 320'(code), rd);
    // pin drivers follow the new instruction one mclk after it loads
    repeat (2) @(negedge mclk);
  endtask
  // bounded wait on the release flag; running out counts as a mismatch
  task automatic wait_rel(input logic exp);
    int k;
    for (k = 0; k < 20 && released !== exp; k++) @(negedge mclk);
    if (k == 20) begin
      failures++;
      $display("ERROR released expected %0h seen %0h", exp, released);
      finish_test();
    end
  endtask
  // capture pattern of the instruction path, then idcode through it
  task automatic t_id();
    tap_u.tap_reset();
    ir(IR_IDCODE);
    `CHK("ir_capture", IR_CAPTURE, rd[IR_W-1:0])
    `CHK("oe_shift", 1'b1, oe_shift)
    `CHK("oe_idle", 1'b0, oe_idle)
    tap_u.scan(1'b0, ID_W, '0, rd);
    `CHK("idcode", ID_VALUE, rd[ID_W-1:0])
    `CHK("id_first", 1'b1, rd[0])
  endtask
  // bypass and an undefined code both give one stage
  task automatic t_byp();
    logic [IR_W-1:0] codes [2];
    codes = '{IR_BYPASS, 10'h155};
    foreach (codes[i]) begin
      ir(codes[i]);
      tap_u.scan(1'b0, 9, 320'h0b5, rd);
      `CHK("bypass", 9'h16a, rd[8:0])
    end
  endtask
  // sample leaves core on the pins; extest drives preload and captures inputs
  task automatic t_bsr();
    logic [BSR_LEN-1:0] pre;
    pre = {9{32'h9669_1249}};
    pins = {9{32'hc3a5_5a3c}};
    ir(IR_SAMPLE);
    `CHK("sample_out", core_o, pin_o)
    `CHK("sample_oe", core_oe, pin_oe)
    tap_u.scan(1'b0, BSR_LEN, 320'(pre), rd);
    `CHK("sample_cap", pins, rd[BSR_LEN-1:0])
    ir(IR_EXTEST);
    `CHK("extest_out", pre, pin_o)
    `CHK("extest_oe", {BSR_LEN{1'b1}}, pin_oe)
    `CHK("small_out", core_o, sm_po)
    `CHK("small_oe", core_oe, sm_poe)
    pins = ~pins;
    tap_u.scan(1'b0, BSR_LEN + 1, 320'(pre), rd);
    `CHK("extest_cap", pins, rd[BSR_LEN-1:0])
    `CHK("bsr_len", pre[0], rd[BSR_LEN])
  endtask
  // program, lock, and erase as the only way back
  task automatic t_isp();
    ir(IR_ISP_ERASE);
    `CHK("isp_pull", 1'b1, pull_up)
    `CHK("isp_oe", {BSR_LEN{1'b0}}, pin_oe)
    ir(IR_ISP_PROG);
    tap_u.scan(1'b0, CFG_W, 320'h3c96_a50f, rd);
    ir(IR_ISP_READ);
    tap_u.scan(1'b0, CFG_W, '0, rd);
    `CHK("cfg_read", 32'h3c96_a50f, rd[CFG_W-1:0])
    ir(IR_ISP_SECURE);
    `CHK("secured", 1'b1, secure)
    ir(IR_ISP_READ);
    tap_u.scan(1'b0, CFG_W, '0, rd);
    `CHK("locked_read", 32'h0, rd[CFG_W-1:0])
    ir(IR_ISP_PROG);
    tap_u.scan(1'b0, CFG_W, '0, rd);
    `CHK("still_secure", 1'b1, secure)
    ir(IR_ISP_ERASE);
    `CHK("unlocked", 1'b0, secure)
    ir(IR_ISP_READ);
    tap_u.scan(1'b0, CFG_W, '0, rd);
    `CHK("erased", CFG_ERASED, rd[CFG_W-1:0])
    tap_u.tap_reset();
    `CHK("pull_off", 1'b0, pull_up)
  endtask
  // a disabled port hands its pins to the user and keeps tdo off
  task automatic t_rel();
    tap_en = 1'b0;
    wait_rel(1'b1);
    `CHK("released", 1'b1, released)
    `CHK("tdo_off", 1'b0, tap_res.tdo_oe)
    tap_en = 1'b1;
    wait_rel(1'b0);
    `CHK("reclaimed", 1'b0, released)
  endtask
  // inputs move on the falling edge; reset held ten cycles
  initial begin
    failures = 0;
    checked = 0;
    rst = 1'b1;
    tap_en = 1'b1;
    pins = '0;
    core_o = {9{32'h0f1e_2d3c}};
    core_oe = {9{32'hf0f0_00ff}};
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    // no release pulse may show right after reset
    repeat (4) begin
      @(negedge mclk);
      `CHK("en_held", 1'b0, released)
    end
    t_id();
    t_byp();
    t_bsr();
    t_isp();
    t_rel();
    finish_test();
  end
endmodule
`default_nettype wire
